// [common/irs_pkg.sv]
// constants and types for the interrupt return, software break and external input block
// ==========================================
// How it works
// - either return pops pc and status word, stack pointer incremented five times
// - maskable return always sets the master enable
// - non-maskable return restores master enable only if it was set at entry
// - both returns decrement the nesting counter and refresh the nesting flag
// - pending requests are sampled in the last cycle of each instruction
// - software break raises the highest priority interrupt at once
// - software break during non-maskable service acts as a no-operation
// - fetch from a non-existent address returns ff, the software break code
// - fetch from ram or register area causes an address-trap reset
// - input zero pin is interrupt or port pin, port after reset
// - inputs one to four have edge select, zero and five falling only
// - one control register holds edge, filter and pin-function selections
// - input one gated by master and enable bit 5, selectable filter
// - inputs two to four gated by bits 7, 11, 12, 7/24 filter
// - noise rejection is off in low-speed mode
// - timer inputs sharing pins with inputs three and four use the filter
// - input one latch set within 49 or 193 fc after a clean edge
// - with pin function off, input zero falling edge sets no latch
// - acceptance clears master enable and source latch, pushes context
// - edges seen while the edge selection changes are ignored
package irs_pkg;
    localparam logic [7:0] IRS_SOFT_BREAK_CODE = 8'hff;
    localparam logic [4:0] IRS_STACK_POP_COUNT = 5'h05;
    localparam logic [3:0] IRS_ACCEPT_CYCLES = 4'hc;
    // control register fields
    localparam int IRS_CTL_ZERO_EN = 0;
    localparam int IRS_CTL_ONE_FILT = 1;
    localparam int IRS_CTL_EDGE_LO = 2;   // bits 2..5: edge for inputs one..four, 1 = rising
    localparam logic [7:0] IRS_CTL_RESET = 8'h00;
    // enable register bit positions
    localparam int IRS_EN_ONE = 5;
    localparam int IRS_EN_TWO = 7;
    localparam int IRS_EN_THREE = 11;
    localparam int IRS_EN_FOUR = 12;
    localparam int IRS_EN_FIVE = 15;
    // apb byte addresses
    localparam logic [7:0] IRS_ADDR_CTL = 8'h00;
    localparam logic [7:0] IRS_ADDR_ENABLE = 8'h04;
    localparam logic [7:0] IRS_ADDR_LATCH = 8'h08;
    localparam logic [7:0] IRS_ADDR_STATUS = 8'h0c;
    // filter lengths in fc cycles (pclk stands for fc)
    localparam logic [7:0] IRS_FILT_ONE_SHORT = 8'h0f;
    localparam logic [7:0] IRS_FILT_ONE_LONG = 8'h3f;
    localparam logic [7:0] IRS_FILT_OTHER = 8'h07;
    typedef enum logic [1:0] {IRS_OP_NONE, IRS_OP_MRET, IRS_OP_NRET, IRS_OP_BREAK} irs_op_type;
endpackage

// [dv/irs_pin_model.sv]
// external interrupt pin source
`timescale 1ns/1ps
module irs_pin_model (
    // clock
    input wire logic pclk,
    // pins, idle high
    output logic [5:0] pins
);
    initial pins = 6'h3f;
    // static task: the index feeds a non-blocking write
    task pulse(input int idx, input int len);
        @(posedge pclk);
        pins[idx] <= 1'b0;
        repeat ((idx == 0 || idx == 5) && len < 9 ? 9 : len) @(posedge pclk);
        pins[idx] <= 1'b1;
        repeat (9) @(posedge pclk);
    endtask
endmodule // irs_pin_model

// [dv/irs_top_props.sv]
// assertion checker for the return, software break and external input block
`timescale 1ns/1ps
module irs_top_props
    import irs_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // cpu core
    input wire irs_pkg::irs_op_type cpu_op,
    input wire logic cpu_fetch,
    input wire logic fetch_nonexist,
    input wire logic fetch_ram_sfr,
    input wire logic cpu_accept,
    input wire logic [7:0] fetch_data_out,
    input wire logic stack_pop,
    input wire logic master_irq_enable,
    input wire logic soft_break_irq,
    input wire logic address_trap_reset
);
    // ==========================================
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_return_op;
        cpu_op == IRS_OP_MRET || cpu_op == IRS_OP_NRET;
    endsequence
    sequence s_pop_burst;
        stack_pop [*5] ##1 !stack_pop;
    endsequence
    property p_pop_five;
        s_return_op |=> s_pop_burst;
    endproperty
    a_pop_five: assert property (p_pop_five) else $error("pop burst length wrong");
    property p_mret_on;
        cpu_op == IRS_OP_MRET |=> master_irq_enable;
    endproperty
    a_mret_on: assert property (p_mret_on) else $error("master enable not set");
    property p_break_cause;
        soft_break_irq |-> $past(cpu_op) == IRS_OP_BREAK;
    endproperty
    a_break_cause: assert property (p_break_cause) else $error("break irq without opcode");
    property p_fetch_code;
        cpu_fetch && fetch_nonexist |=> fetch_data_out == IRS_SOFT_BREAK_CODE;
    endproperty
    a_fetch_code: assert property (p_fetch_code) else $error("missing fetch not ff");
    property p_trap;
        cpu_fetch && fetch_ram_sfr |=> address_trap_reset;
    endproperty
    a_trap: assert property (p_trap) else $error("no address trap");
    property p_accept_mask;
        cpu_accept |=> !master_irq_enable;
    endproperty
    a_accept_mask: assert property (p_accept_mask) else $error("accept left master on");
    property p_apb_answer;
        psel && !penable |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no ready after setup");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule // irs_top_props

bind irs_top irs_top_props u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .cpu_op, .cpu_fetch,
    .fetch_nonexist, .fetch_ram_sfr, .cpu_accept, .fetch_data_out, .stack_pop, .master_irq_enable,
    .soft_break_irq, .address_trap_reset);

// [dv/tb.sv]
// self-checking testbench for the return, software break and external input block
`timescale 1ns/1ps
module tb;
    import irs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, fetch_data_in, fetch_data_out;
    logic [31:0] pwdata, prdata, rd;
    irs_op_type cpu_op;
    logic cpu_last_cycle, cpu_fetch, fetch_nonexist, fetch_ram_sfr, cpu_accept, nmi_accept, low_speed_mode;
    logic [2:0] accept_src, irq_take_src;
    logic stack_pop, stack_push, master_irq_enable, nest_flag, soft_break_irq, irq_take, address_trap_reset;
    logic port_one_bit_zero, timer_input_one, timer_input_three;
    logic [5:0] pins;
    int failures = 0;
    int checks = 0;
    irs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_op,
        .cpu_last_cycle, .cpu_fetch, .fetch_nonexist, .fetch_ram_sfr, .fetch_data_in, .cpu_accept, .accept_src,
        .nmi_accept, .low_speed_mode, .fetch_data_out, .stack_pop, .stack_push, .master_irq_enable, .nest_flag,
        .soft_break_irq, .irq_take, .irq_take_src, .address_trap_reset, .ext_irq_zero_n(pins[0]),
        .ext_irq_one(pins[1]), .ext_irq_two(pins[2]), .ext_irq_three(pins[3]), .ext_irq_four(pins[4]),
        .ext_irq_five_n(pins[5]), .port_one_bit_zero, .timer_input_one, .timer_input_three);
    irs_pin_model pin_src (.pclk, .pins);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ==========================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cpu(input irs_op_type o, input logic nmi, input logic acc);
        @(posedge pclk);
        cpu_op <= o;
        nmi_accept <= nmi;
        cpu_accept <= acc;
        @(posedge pclk);
        cpu_op <= IRS_OP_NONE;
        nmi_accept <= 1'b0;
        cpu_accept <= 1'b0;
        #1;
    endtask
    task automatic latch_is(input int b, input logic exp, input string what);
        apb(1'b0, IRS_ADDR_LATCH, 32'h0);
        check(what, exp, rd[b]);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        check("port pin", 1'b1, port_one_bit_zero);
        apb(1'b0, IRS_ADDR_CTL, 32'h0);
        check("control", IRS_CTL_RESET, rd);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", 1'b1, err);
        check("unmapped data", 32'h0, rd);
    endtask
    task automatic t_returns;
        int n;
        n = 0;
        apb(1'b1, IRS_ADDR_ENABLE, 32'h0);
        cpu(IRS_OP_MRET, 1'b0, 1'b0);
        check("mret master", 1'b1, master_irq_enable);
        repeat (8) begin
            n += int'(stack_pop === 1'b1);
            @(posedge pclk);
            #1;
        end
        check("pop cycles", 32'h5, n);
        apb(1'b1, IRS_ADDR_ENABLE, 32'h0);
        cpu(IRS_OP_NONE, 1'b1, 1'b0);
        cpu(IRS_OP_NRET, 1'b0, 1'b0);
        check("nret off", 1'b0, master_irq_enable);
        apb(1'b1, IRS_ADDR_ENABLE, 32'h1);
        cpu(IRS_OP_NONE, 1'b1, 1'b0);
        apb(1'b1, IRS_ADDR_ENABLE, 32'h0);
        cpu(IRS_OP_NRET, 1'b0, 1'b0);
        check("nret cleared", 1'b0, master_irq_enable);
        apb(1'b1, IRS_ADDR_ENABLE, 32'h1);
        cpu(IRS_OP_NONE, 1'b1, 1'b0);
        cpu(IRS_OP_NRET, 1'b0, 1'b0);
        check("nret on", 1'b1, master_irq_enable);
    endtask
    task automatic t_break;
        cpu(IRS_OP_BREAK, 1'b0, 1'b0);
        check("break", 1'b1, soft_break_irq);
        cpu(IRS_OP_BREAK, 1'b0, 1'b0);
        check("nested break", 1'b0, soft_break_irq);
        cpu(IRS_OP_NRET, 1'b0, 1'b0);
        cpu(IRS_OP_NONE, 1'b1, 1'b0);
        cpu(IRS_OP_BREAK, 1'b0, 1'b0);
        check("break in nmi", 1'b0, soft_break_irq);
        repeat (6) @(posedge pclk);
        cpu(IRS_OP_NRET, 1'b0, 1'b0);
    endtask
    task automatic t_fetch;
        @(posedge pclk);
        cpu_fetch <= 1'b1;
        fetch_nonexist <= 1'b1;
        fetch_data_in <= 8'h12;
        @(posedge pclk);
        fetch_nonexist <= 1'b0;
        fetch_ram_sfr <= 1'b1;
        #1;
        check("missing fetch", IRS_SOFT_BREAK_CODE, fetch_data_out);
        @(posedge pclk);
        cpu_fetch <= 1'b0;
        fetch_ram_sfr <= 1'b0;
        #1;
        check("trap", 1'b1, address_trap_reset);
        check("fetch pass", 8'h12, fetch_data_out);
    endtask
    task automatic t_ext_one;
        int n;
        apb(1'b1, IRS_ADDR_CTL, 32'h1);
        apb(1'b1, IRS_ADDR_ENABLE, 32'h21);
        apb(1'b1, IRS_ADDR_LATCH, 32'h0);
        pin_src.pulse(1, 48);
        latch_is(1, 1'b0, "long filter");
        apb(1'b1, IRS_ADDR_CTL, 32'h3);
        pin_src.pulse(1, 10);
        latch_is(1, 1'b0, "short reject");
        pin_src.pulse(1, 48);
        latch_is(1, 1'b1, "short accept");
        accept_src <= 3'h1;
        cpu_last_cycle <= 1'b1;
        for (n = 0; n < 20 && irq_take !== 1'b1; n++) @(posedge pclk);
        check("take", 1'b1, irq_take);
        check("take src", 3'h1, irq_take_src);
        cpu_last_cycle <= 1'b0;
        cpu(IRS_OP_NONE, 1'b0, 1'b1);
        check("accept master", 1'b0, master_irq_enable);
        check("nest up", 1'b1, nest_flag);
        n = 0;
        repeat (8) begin
            n += int'(stack_push === 1'b1);
            @(posedge pclk);
            #1;
        end
        check("push cycles", 32'h5, n);
        latch_is(1, 1'b0, "accept latch");
        repeat (8) @(posedge pclk);
        cpu(IRS_OP_MRET, 1'b0, 1'b0);
        repeat (6) @(posedge pclk);
        #1;
        check("nest down", 1'b0, nest_flag);
    endtask
    task automatic t_ext_pins;
        apb(1'b1, IRS_ADDR_CTL, 32'h0);
        apb(1'b1, IRS_ADDR_LATCH, 32'h0);
        fork
            pin_src.pulse(0, 9);
            begin
                repeat (7) @(posedge pclk);
                #1;
                check("port follows pin", 1'b0, port_one_bit_zero);
            end
        join
        latch_is(0, 1'b0, "zero off");
        apb(1'b1, IRS_ADDR_CTL, 32'h1);
        pin_src.pulse(0, 9);
        latch_is(0, 1'b1, "zero on");
        pin_src.pulse(5, 9);
        latch_is(5, 1'b1, "five");
        pin_src.pulse(2, 5);
        latch_is(2, 1'b0, "two reject");
        pin_src.pulse(2, 24);
        latch_is(2, 1'b1, "two accept");
        apb(1'b1, IRS_ADDR_LATCH, 32'h0);
        low_speed_mode <= 1'b1;
        pin_src.pulse(2, 5);
        latch_is(2, 1'b1, "slow bypass");
        low_speed_mode <= 1'b0;
    endtask
    task automatic t_ext_edges;
        // input three switched to rising edge, input four left on falling
        apb(1'b1, IRS_ADDR_CTL, 32'h1 | (32'h1 << (IRS_CTL_EDGE_LO + 2)));
        apb(1'b1, IRS_ADDR_LATCH, 32'h0);
        fork
            pin_src.pulse(3, 40);
            begin
                repeat (25) @(posedge pclk);
                latch_is(3, 1'b0, "three on falling");
                #1;
                check("timer one low", 1'b0, timer_input_one);
            end
        join
        // the rising edge is only seen once the filter has passed the high level
        repeat (10) @(posedge pclk);
        latch_is(3, 1'b1, "three on rising");
        fork
            pin_src.pulse(4, 40);
            begin
                repeat (30) @(posedge pclk);
                #1;
                check("timer three low", 1'b0, timer_input_three);
            end
        join
        repeat (10) @(posedge pclk);
        #1;
        check("timer three high", 1'b1, timer_input_three);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        finish_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, cpu_last_cycle, cpu_fetch, fetch_nonexist} = '0;
        {fetch_ram_sfr, fetch_data_in, cpu_accept, accept_src, nmi_accept, low_speed_mode} = '0;
        cpu_op = IRS_OP_NONE;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_returns;
        t_break;
        t_fetch;
        t_ext_one;
        t_ext_pins;
        t_ext_edges;
        finish_test;
    end
endmodule // tb

// [verilog/irs_filter.sv]
// noise reject filter with edge detection for one interrupt input
`timescale 1ns/1ps
module irs_filter (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic [7:0] filt_len,
    input wire logic filt_on,
    input wire logic rising_sel,
    // pin and results
    input wire logic pin_in,
    output logic level_out,
    output logic edge_out
);
    logic [2:0] sync_reg;
    logic level_reg;
    logic [7:0] count_reg;
    logic sel_reg;
    wire stable = (sync_reg[1] == sync_reg[2]);
    wire differs = stable && (sync_reg[2] != level_reg);
    wire pass = differs && (!filt_on || count_reg >= filt_len);
    wire new_level = sync_reg[2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg <= 3'h7;
            level_reg <= 1'b1;
            count_reg <= 8'h00;
            sel_reg <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_in};
            sel_reg <= rising_sel;
            count_reg <= (differs && !pass && count_reg != 8'hff) ? count_reg + 8'h01 : 8'h00;
            if (pass) begin
                level_reg <= new_level;
            end
            // edge during a selection change is dropped
            edge_out <= pass && (sel_reg == rising_sel) && (new_level == rising_sel);
        end
    end
    assign level_out = level_reg;
endmodule // irs_filter

// [verilog/irs_top.sv]
// interrupt return, software break and external input logic with apb registers
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module irs_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu core
    input wire irs_pkg::irs_op_type cpu_op,
    input wire logic cpu_last_cycle,
    input wire logic cpu_fetch,
    input wire logic fetch_nonexist,
    input wire logic fetch_ram_sfr,
    input wire logic [7:0] fetch_data_in,
    input wire logic cpu_accept,
    input wire logic [2:0] accept_src,
    input wire logic nmi_accept,
    input wire logic low_speed_mode,
    output logic [7:0] fetch_data_out,
    output logic stack_pop,
    output logic stack_push,
    output logic master_irq_enable,
    output logic nest_flag,
    output logic soft_break_irq,
    output logic irq_take,
    output logic [2:0] irq_take_src,
    output logic address_trap_reset,
    // pins
    input wire logic ext_irq_zero_n,
    input wire logic ext_irq_one,
    input wire logic ext_irq_two,
    input wire logic ext_irq_three,
    input wire logic ext_irq_four,
    input wire logic ext_irq_five_n,
    output logic port_one_bit_zero,
    output logic timer_input_one,
    output logic timer_input_three
);
    import irs_pkg::*;

    // ==========================================
    // registers
    logic [7:0] ext_irq_control_reg;
    logic [15:0] enable_reg;
    logic [5:0] irq_request_latch;
    logic master_reg;
    logic nmi_active_reg;
    logic nmi_saved_master_reg;
    logic [3:0] nest_count_reg;
    logic [4:0] pop_count_reg;
    logic [3:0] accept_count_reg;
    logic [2:0] z_sync_reg;
    logic [2:0] f_sync_reg;
    logic z_prev_reg;
    logic f_prev_reg;

    // ==========================================
    // apb decode
    wire apb_wr = psel && penable && pwrite;
    wire sel_ctl = (paddr == IRS_ADDR_CTL);
    wire sel_en = (paddr == IRS_ADDR_ENABLE);
    wire sel_latch = (paddr == IRS_ADDR_LATCH);
    wire sel_stat = (paddr == IRS_ADDR_STATUS);
    wire mapped = sel_ctl || sel_en || sel_latch || sel_stat;
    wire ctl_wr = apb_wr && sel_ctl;
    wire en_wr = apb_wr && sel_en;
    wire latch_wr = apb_wr && sel_latch;
    wire [31:0] rd_mux = sel_ctl ? {24'h000000, ext_irq_control_reg} :
                         sel_en ? {16'h0000, enable_reg[15:1], master_reg} :
                         sel_latch ? {26'h0000000, irq_request_latch} :
                         sel_stat ? {22'h000000, nest_count_reg, nmi_active_reg, nmi_saved_master_reg,
                                     nest_flag, soft_break_irq, 2'h0} : 32'h00000000;

    // ==========================================
    // external inputs
    wire filt_on = !low_speed_mode;
    wire [7:0] one_len = ext_irq_control_reg[IRS_CTL_ONE_FILT] ? IRS_FILT_ONE_SHORT : IRS_FILT_ONE_LONG;
    wire [3:0] pins = {ext_irq_four, ext_irq_three, ext_irq_two, ext_irq_one};
    wire [3:0] f_edge;
    wire [3:0] f_level;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            irs_filter u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .filt_len(gi == 0 ? one_len : IRS_FILT_OTHER),
                .filt_on(filt_on),
                .rising_sel(ext_irq_control_reg[IRS_CTL_EDGE_LO + gi]),
                .pin_in(pins[gi]),
                .level_out(f_level[gi]),
                .edge_out(f_edge[gi])
            );
        end
    endgenerate
    // unfiltered inputs: three-flop sync, falling edge when stages agree
    wire z_fall = (z_sync_reg[1] == z_sync_reg[2]) && !z_sync_reg[2] && z_prev_reg;
    wire f_fall = (f_sync_reg[1] == f_sync_reg[2]) && !f_sync_reg[2] && f_prev_reg;
    wire zero_set = z_fall && ext_irq_control_reg[IRS_CTL_ZERO_EN];
    wire [5:0] latch_set = {f_fall, f_edge, zero_set};

    // ==========================================
    // cpu side
    wire mret = (cpu_op == IRS_OP_MRET);
    wire nret = (cpu_op == IRS_OP_NRET);
    wire do_ret = mret || nret;
    wire break_ok = (cpu_op == IRS_OP_BREAK) && !nmi_active_reg;
    wire [5:0] gate = {master_reg && enable_reg[IRS_EN_FIVE], master_reg && enable_reg[IRS_EN_FOUR],
                       master_reg && enable_reg[IRS_EN_THREE], master_reg && enable_reg[IRS_EN_TWO],
                       master_reg && enable_reg[IRS_EN_ONE], master_reg};
    wire [5:0] ready_req = irq_request_latch & gate;
    function automatic logic [2:0] first_src(input logic [5:0] v);
        first_src = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (v[i]) begin
                first_src = i[2:0];
            end
        end
    endfunction
    wire [5:0] acc_clear = cpu_accept ? (6'h01 << accept_src) : 6'h00;
    wire [5:0] latch_next = (irq_request_latch & ~acc_clear & ~(latch_wr ? ~pwdata[5:0] : 6'h00)) | latch_set;
    wire master_next = en_wr ? pwdata[0] :
                       (cpu_accept || nmi_accept) ? 1'b0 :
                       mret ? 1'b1 :
                       nret ? nmi_saved_master_reg : master_reg;
    wire [3:0] nest_next = (cpu_accept || nmi_accept) ? nest_count_reg + 4'h1 :
                           (do_ret && nest_count_reg != 4'h0) ? nest_count_reg - 4'h1 : nest_count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_control_reg <= IRS_CTL_RESET;
            enable_reg <= 16'h0000;
            irq_request_latch <= 6'h00;
            master_reg <= 1'b0;
            nest_count_reg <= 4'h0;
        end else begin
            if (ctl_wr) begin
                ext_irq_control_reg <= pwdata[7:0];
            end
            if (en_wr) begin
                enable_reg <= pwdata[15:0];
            end
            irq_request_latch <= latch_next;
            master_reg <= master_next;
            nest_count_reg <= nest_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_active_reg <= 1'b0;
            nmi_saved_master_reg <= 1'b0;
        end else begin
            if (nmi_accept || break_ok) begin
                nmi_active_reg <= 1'b1;
                nmi_saved_master_reg <= master_reg;
            end else if (nret) begin
                nmi_active_reg <= 1'b0;
            end else if (nmi_active_reg && en_wr && !pwdata[0]) begin
                // service routine turned the master enable off: the return must keep it off
                nmi_saved_master_reg <= 1'b0;
            end
        end
    end

    // pop and push sequencers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_count_reg <= 5'h00;
            accept_count_reg <= 4'h0;
        end else begin
            if (do_ret) begin
                pop_count_reg <= IRS_STACK_POP_COUNT;
            end else if (pop_count_reg != 5'h00) begin
                pop_count_reg <= pop_count_reg - 5'h01;
            end
            if (cpu_accept || nmi_accept) begin
                accept_count_reg <= IRS_ACCEPT_CYCLES;
            end else if (accept_count_reg != 4'h0) begin
                accept_count_reg <= accept_count_reg - 4'h1;
            end
        end
    end

    // raw pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_sync_reg <= 3'h7;
            f_sync_reg <= 3'h7;
            z_prev_reg <= 1'b1;
            f_prev_reg <= 1'b1;
        end else begin
            z_sync_reg <= {z_sync_reg[1:0], ext_irq_zero_n};
            f_sync_reg <= {f_sync_reg[1:0], ext_irq_five_n};
            if (z_sync_reg[1] == z_sync_reg[2]) begin
                z_prev_reg <= z_sync_reg[2];
            end
            if (f_sync_reg[1] == f_sync_reg[2]) begin
                f_prev_reg <= f_sync_reg[2];
            end
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            fetch_data_out <= 8'h00;
            stack_pop <= 1'b0;
            stack_push <= 1'b0;
            master_irq_enable <= 1'b0;
            nest_flag <= 1'b0;
            soft_break_irq <= 1'b0;
            irq_take <= 1'b0;
            irq_take_src <= 3'h0;
            address_trap_reset <= 1'b0;
            port_one_bit_zero <= 1'b1;
            timer_input_one <= 1'b1;
            timer_input_three <= 1'b1;
        end else begin
            // no wait state: answer in the cycle after setup
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
            fetch_data_out <= fetch_nonexist ? IRS_SOFT_BREAK_CODE : fetch_data_in;
            address_trap_reset <= cpu_fetch && fetch_ram_sfr;
            stack_pop <= do_ret || pop_count_reg > 5'h01;
            stack_push <= accept_count_reg > 4'h7;
            master_irq_enable <= master_next;
            nest_flag <= (nest_next != 4'h0);
            soft_break_irq <= break_ok;
            irq_take <= cpu_last_cycle && !break_ok && (ready_req != 6'h00);
            irq_take_src <= first_src(ready_req);
            port_one_bit_zero <= ext_irq_control_reg[IRS_CTL_ZERO_EN] ? 1'b1 : z_prev_reg;
            timer_input_one <= f_level[2];
            timer_input_three <= f_level[3];
        end
    end
endmodule // irs_top
